// ===== sba_arbiter.sv
`timescale 1ns/1ps
module sba_arbiter
    import sba_pkg::*;
#(
    parameter int N = NUM_BR
) (
    // Clock and reset
    input  wire logic            i_sys_clk,
    input  wire logic            i_rst,
    // Host side
    input  wire logic            i_host_bus_request_n,
    input  wire logic            i_host_select_a_n,
    input  wire logic            i_host_select_b_n,
    input  wire logic            i_host_select_c_n,
    input  wire logic            i_host_select_d_n,
    input  wire logic            i_host_bus_grant_n,
    output logic                 o_host_bus_grant_n,
    output logic                 o_host_bus_grant_oe,
    output logic                 o_host_wait_ack_n,
    output logic                 o_host_wait_ack_oe,
    // Per-processor host access status and configuration
    input  wire logic [3:0]      i_host_access_busy,
    input  wire logic [3:0]      i_host_ack_active_drive_bit,
    // Multiprocessor arbitration
    input  wire logic [N-1:0]    i_mp_bus_request_n,
    output logic [N-1:0]         o_mp_bus_request_n,
    output logic [N-1:0]         o_mp_bus_request_oe,
    input  wire logic [3:0]      i_local_want_bus,
    input  wire logic            i_arbitration_rotate_select,
    // Bus ownership
    output logic [2:0]           o_bus_master,
    output logic                 o_bus_drive_en
);
    sba_hg_state_t hg_state, next_hg_state;
    logic [2:0]    master, next_master;
    logic [2:0]    last, next_last;
    logic          grant_n, next_grant_n;
    logic          grant_oe, next_grant_oe;
    logic          drive_en, next_drive_en;
    logic          ack_n, next_ack_n;
    logic          ack_oe, next_ack_oe;
    logic [N-1:0]  br_n, next_br_n;
    logic [N-1:0]  br_oe, next_br_oe;
    logic [N-1:0]  req;
    logic          found;
    logic [2:0]    winner;
    logic [3:0]    sel;
    logic [2:0]    local_id [NUM_LOCAL];
    logic          host_req;
    logic          local_master;

    assign local_id[0] = ID_A;
    assign local_id[1] = ID_B;
    assign local_id[2] = ID_C;
    assign local_id[3] = ID_D;
    assign host_req = ~i_host_bus_request_n;
    // Select lines each address one processor
    assign sel = ~{i_host_select_d_n, i_host_select_c_n,
                   i_host_select_b_n, i_host_select_a_n};
    assign local_master = (master >= ID_A) && (master <= ID_D);

    // Request vector seen on the shared lines, own drives included
    generate
        for (genvar g = 0; g < N; g++) begin : g_req
            assign req[g] = ~i_mp_bus_request_n[g] | ~br_n[g];
        end
    endgenerate

    sba_priority #(
        .N (N)
    ) u_prio (
        .i_req    (req),
        .i_rotate (i_arbitration_rotate_select),
        .i_last   (last),
        .o_found  (found),
        .o_winner (winner)
    );

    // Request drivers: each local processor owns only its numbered line
    always_comb begin
        next_br_n  = BR_IDLE;
        next_br_oe = '0;
        for (int p = 0; p < NUM_LOCAL; p++) begin
            next_br_oe[local_id[p] - 3'h1] = 1'b1;
            next_br_n[local_id[p] - 3'h1]  = ~i_local_want_bus[p];
        end
    end

    // Host grant sequence and processor mastership
    always_comb begin
        next_hg_state = hg_state;
        next_master   = master;
        next_last     = last;
        next_drive_en = drive_en;
        next_grant_n  = grant_n;
        next_grant_oe = grant_oe;
        unique case (hg_state)
            SBA_HG_IDLE: begin
                if (host_req) begin
                    // Host outranks every processor request
                    next_drive_en = 1'b0;
                    next_hg_state = SBA_HG_RELEASE;
                end else if (!found) begin
                    next_master   = MASTER_NONE;
                    next_drive_en = 1'b0;
                end else begin
                    // Rotation point moves only when mastership changes
                    if (winner != master) begin
                        if (master != MASTER_NONE)
                            next_last = master;
                        next_master = winner;
                    end
                    // A local master takes the bus back once the host has left,
                    // even when the same processor wins again
                    next_drive_en = (winner >= ID_A) && (winner <= ID_D);
                end
                // Only a local master drives the grant line, else monitor
                next_grant_oe = local_master;
                next_grant_n  = 1'b1;
            end
            SBA_HG_RELEASE: begin
                // Bus lines already floated one cycle earlier
                if (!host_req) begin
                    next_hg_state = SBA_HG_IDLE;
                end else begin
                    next_grant_n  = 1'b0;
                    next_grant_oe = local_master;
                    next_hg_state = SBA_HG_GRANTED;
                end
            end
            SBA_HG_GRANTED: begin
                if (!host_req) begin
                    next_grant_n  = 1'b1;
                    next_hg_state = SBA_HG_IDLE;
                end
            end
            default: begin
                next_hg_state = SBA_HG_IDLE;
            end
        endcase
    end

    // Wait acknowledge: driven only with request and a local select
    always_comb begin
        next_ack_n  = 1'b1;
        next_ack_oe = 1'b0;
        for (int p = 0; p < NUM_LOCAL; p++) begin
            if (host_req && sel[p]) begin
                if (i_host_access_busy[p]) begin
                    next_ack_n  = 1'b0;
                    next_ack_oe = 1'b1;
                end else if (i_host_ack_active_drive_bit[p]) begin
                    next_ack_oe = 1'b1;
                end
            end
        end
    end

    // Registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            hg_state <= SBA_HG_IDLE;
            master   <= MASTER_NONE;
            last     <= LAST_RESET;
            grant_n  <= 1'b1;
            grant_oe <= 1'b0;
            drive_en <= 1'b0;
            ack_n    <= 1'b1;
            ack_oe   <= ACK_MODE_RESET;
            br_n     <= BR_IDLE;
            br_oe    <= '0;
        end else begin
            hg_state <= next_hg_state;
            master   <= next_master;
            last     <= next_last;
            grant_n  <= next_grant_n;
            grant_oe <= next_grant_oe;
            drive_en <= next_drive_en;
            ack_n    <= next_ack_n;
            ack_oe   <= next_ack_oe;
            br_n     <= next_br_n;
            br_oe    <= next_br_oe;
        end
    end

    assign o_host_bus_grant_n  = grant_n;
    assign o_host_bus_grant_oe = grant_oe;
    assign o_host_wait_ack_n   = ack_n;
    assign o_host_wait_ack_oe  = ack_oe;
    assign o_mp_bus_request_n  = br_n;
    assign o_mp_bus_request_oe = br_oe;
    assign o_bus_master        = master;
    assign o_bus_drive_en      = drive_en;
endmodule

// ===== sba_pkg.sv
package sba_pkg;
    // Bus geometry
    localparam int NUM_BR       = 6;   // Multiprocessor request lines 6..1
    localparam int NUM_LOCAL    = 4;   // Processors inside the module
    localparam int ID_W         = 3;   // Processor number width
    localparam int BR_IDX_W     = 3;   // Index into request vector
    // Processor numbers of the four local processors
    localparam logic [2:0] ID_A = 3'h1;
    localparam logic [2:0] ID_B = 3'h2;
    localparam logic [2:0] ID_C = 3'h3;
    localparam logic [2:0] ID_D = 3'h4;
    // Reset values
    localparam logic [2:0] MASTER_NONE = 3'h0;   // No master
    localparam logic [2:0] LAST_RESET  = 3'h0;
    localparam logic       ACK_MODE_RESET = 1'b0; // Open drain after reset
    localparam logic [5:0] BR_IDLE     = 6'h3F;
    // Host grant sequencing
    typedef enum logic [1:0] {
        SBA_HG_IDLE    = 2'b00,
        SBA_HG_RELEASE = 2'b01,
        SBA_HG_GRANTED = 2'b10
    } sba_hg_state_t;
endpackage

// ===== sba_priority.sv
`timescale 1ns/1ps
// Picks the winning request among six lines, fixed or rotating
module sba_priority
    import sba_pkg::*;
#(
    parameter int N = NUM_BR
) (
    // Requests, active high, bit k is processor number k+1
    input  wire logic [N-1:0]  i_req,
    // Scheme and rotation point
    input  wire logic          i_rotate,
    input  wire logic [2:0]    i_last,
    // Result
    output logic               o_found,
    output logic [2:0]         o_winner
);
    // Fixed: lowest number wins; rotating: search starts after last master
    always_comb begin
        int k;
        int idx;
        int start;
        k        = 0;
        idx      = 0;
        start    = 0;
        o_found  = 1'b0;
        o_winner = MASTER_NONE;
        start    = (i_rotate && i_last != MASTER_NONE) ? int'(i_last) : 0;
        for (k = 0; k < N; k++) begin
            idx = (start + k) % N;
            if (!o_found && i_req[idx]) begin
                o_found  = 1'b1;
                o_winner = 3'(idx + 1);
            end
        end
    end
endmodule

// ===== sba_asserts.sv
`timescale 1ns/1ps
// Port checks; outputs are registered, so effects land one edge late
module sba_asserts
    import sba_pkg::*;
#(parameter int N = NUM_BR) (
    input wire logic         i_sys_clk,
    input wire logic         i_rst,
    input wire logic         i_host_bus_request_n,
    input wire logic         i_host_select_a_n,
    input wire logic         i_host_select_b_n,
    input wire logic         i_host_select_c_n,
    input wire logic         i_host_select_d_n,
    input wire logic [3:0]   i_host_access_busy,
    input wire logic [3:0]   i_host_ack_active_drive_bit,
    input wire logic         o_host_bus_grant_n,
    input wire logic         o_host_wait_ack_n,
    input wire logic         o_host_wait_ack_oe,
    input wire logic         o_bus_drive_en,
    input wire logic [N-1:0] o_mp_bus_request_oe
);
    wire logic [3:0] sel_n = {i_host_select_d_n, i_host_select_c_n,
                              i_host_select_b_n, i_host_select_a_n};
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence s_take; $fell(i_host_bus_request_n) && o_host_bus_grant_n; endsequence
    sequence s_acc_a; !i_host_bus_request_n && sel_n == 4'hE; endsequence
    property p_grant; s_take |-> ##2 !o_host_bus_grant_n; endproperty
    property p_hold; !o_host_bus_grant_n && !i_host_bus_request_n |=> !o_host_bus_grant_n;
    endproperty
    property p_free; $rose(i_host_bus_request_n) |-> ##[1:2] o_host_bus_grant_n; endproperty
    property p_quiet; !i_host_bus_request_n |=> !o_bus_drive_en; endproperty
    property p_wait; s_acc_a ##0 i_host_access_busy[0] |=> !o_host_wait_ack_n && o_host_wait_ack_oe;
    endproperty
    property p_mode; s_acc_a ##0 !i_host_access_busy[0]
        |=> o_host_wait_ack_oe == $past(i_host_ack_active_drive_bit[0]); endproperty
    property p_undrv; o_host_wait_ack_oe
        |-> !$past(i_host_bus_request_n) && $past(sel_n) != 4'hF; endproperty
    property p_own; o_mp_bus_request_oe[N-1:4] == '0; endproperty
    a_grant: assert property (p_grant) else $error("grant late");
    a_hold: assert property (p_hold) else $error("grant dropped");
    a_free: assert property (p_free) else $error("grant stuck");
    a_quiet: assert property (p_quiet) else $error("bus not released");
    a_wait: assert property (p_wait) else $error("no wait state");
    a_mode: assert property (p_mode) else $error("ack drive mode");
    a_undrv: assert property (p_undrv) else $error("ack driven idle");
    a_own: assert property (p_own) else $error("foreign request line");
endmodule

// ===== sba_host_model.sv
`timescale 1ns/1ps
// Host processor plus two absent peers on the shared lines
module sba_host_model (
    input  wire logic       i_sys_clk,
    // Lines as driven by the module
    input  wire logic       i_grant_n,
    input  wire logic       i_grant_oe,
    input  wire logic       i_ack_n,
    input  wire logic       i_ack_oe,
    input  wire logic [5:0] i_br_n,
    input  wire logic [5:0] i_br_oe,
    // Host drive and resolved wires
    output logic            o_hbr_n,
    output logic [3:0]      o_sel_n,
    output logic            o_grant_line_n,
    output logic            o_ack_line_n,
    output logic [5:0]      o_br_line_n
);
    logic t = 1'b0;
    // Undriven lines without a pull wander, so stale values cannot pass
    always @(posedge i_sys_clk) t <= !t;
    assign o_grant_line_n = i_grant_oe ? i_grant_n : t;
    assign o_ack_line_n = i_ack_oe ? i_ack_n : 1'b1;
    // Absent peers 6..5 are pulled high; 4..1 never are
    always_comb begin
        for (int k = 0; k < 6; k++)
            o_br_line_n[k] = i_br_oe[k] ? i_br_n[k] : (k > 3 ? 1'b1 : t);
    end
    initial begin
        o_hbr_n = 1'b1;
        o_sel_n = 4'hF;
    end
    // Request level plus at most one select; index 4 selects nobody
    task automatic host(input logic req, input int idx);
        o_hbr_n = !req;
        o_sel_n = (idx < 4) ? ~(4'h1 << idx) : 4'hF;
    endtask
endmodule

// ===== sba_arbiter_tb.sv
`timescale 1ns/1ps
module sba_arbiter_tb;
    import sba_pkg::*;
    logic i_sys_clk, i_rst = 1'b1, rot = 1'b0, hbr_n, gl_n, g_n, g_oe, a_n, a_oe, al_n, den;
    logic [3:0] sel_n, busy = 4'h0, drv = 4'h0, want = 4'h0;
    logic [5:0] brl_n, br_n, br_oe;
    logic [2:0] master, prev = 3'h0, exp_q[$];
    int errors = 0, tests_run = 0;
    sba_arbiter sba_arbiter_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_host_bus_request_n(hbr_n), .i_host_select_a_n(sel_n[0]),
        .i_host_select_b_n(sel_n[1]), .i_host_select_c_n(sel_n[2]),
        .i_host_select_d_n(sel_n[3]), .i_host_bus_grant_n(gl_n), .o_host_bus_grant_n(g_n),
        .o_host_bus_grant_oe(g_oe), .o_host_wait_ack_n(a_n), .o_host_wait_ack_oe(a_oe),
        .i_host_access_busy(busy), .i_host_ack_active_drive_bit(drv),
        .i_mp_bus_request_n(brl_n), .o_mp_bus_request_n(br_n), .o_mp_bus_request_oe(br_oe),
        .i_local_want_bus(want), .i_arbitration_rotate_select(rot),
        .o_bus_master(master), .o_bus_drive_en(den));
    sba_host_model sba_host_model_inst (.i_sys_clk(i_sys_clk), .i_grant_n(g_n),
        .i_grant_oe(g_oe), .i_ack_n(a_n), .i_ack_oe(a_oe), .i_br_n(br_n), .i_br_oe(br_oe),
        .o_hbr_n(hbr_n), .o_sel_n(sel_n), .o_grant_line_n(gl_n), .o_ack_line_n(al_n),
        .o_br_line_n(brl_n));
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = !i_sys_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Bounded wait until every noted master has shown up
    task automatic settle;
        repeat (20) if (exp_q.size() != 0) @(negedge i_sys_clk);
        if (exp_q.size() != 0) begin
            check("pending", 8'(exp_q.size()), 8'h0);
            print_verdict();
        end
    endtask
    // Each new nonzero master is matched against the oldest note
    always @(negedge i_sys_clk) begin
        if (!i_rst && master !== prev && master !== 3'h0)
            check("master", master, exp_q.size() ? exp_q.pop_front() : 8'hFF);
        prev <= master;
    end
    initial begin
        #100us;
        errors++;
        print_verdict();
    end
    initial begin
        int k;
        void'($urandom(22));
        repeat (12) @(negedge i_sys_clk);
        i_rst = 1'b0;
        check("reset grant", {g_n, g_oe, a_oe, den, 1'b0, master}, 8'h80);
        check("reset req", {2'b00, br_n}, 8'h3F);
        check("reset req oe", {2'b00, br_oe}, 8'h00);
        exp_q.push_back(ID_A);
        want = 4'h5;
        settle();
        exp_q.push_back(ID_C);
        want = 4'h4;
        settle();
        check("req lines", {2'b00, br_n}, 8'h3B);
        check("req oe", {2'b00, br_oe}, 8'h0F);
        check("drive", den, 1'b1);
        // Host takes the bus while processor C is master
        sba_host_model_inst.host(1'b1, 4);
        repeat (3) @(negedge i_sys_clk);
        check("grant", {g_n, g_oe, den}, 8'h02);
        want = 4'h9;
        rot = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        check("frozen", master, ID_C);
        check("held", g_n, 1'b0);
        exp_q.push_back(ID_D);
        sba_host_model_inst.host(1'b0, 4);
        repeat (2) @(negedge i_sys_clk);
        check("release", g_n, 1'b1);
        settle();
        check("drive back", den, 1'b1);
        exp_q.push_back(ID_A);
        want = 4'h1;
        settle();
        // Random busy and drive mode under every select choice
        sba_host_model_inst.host(1'b1, 4);
        repeat (3) @(negedge i_sys_clk);
        for (int i = 0; i < 15; i++) begin
            k = i % 5;
            busy = 4'($urandom);
            drv = 4'($urandom);
            sba_host_model_inst.host(1'b1, k);
            @(negedge i_sys_clk);
            check("ack_oe", a_oe, k < 4 && (busy[k] || drv[k]));
            check("ack_line", al_n, !(k < 4 && busy[k]));
        end
        busy = 4'hF;
        sba_host_model_inst.host(1'b0, 0);
        @(negedge i_sys_clk);
        check("ack_idle", a_oe, 1'b0);
        print_verdict();
    end
endmodule
bind sba_arbiter sba_asserts #(.N(N)) sba_asserts_inst (.*);
